// ===== hdl/ssh_pkg.sv
// search sorter device port: shared constants and carrier types
// assumes a single 200 MHz clock and pins synchronised inside the top
`default_nettype none
package ssh_pkg;
  // clock rate in MHz; nothing in the project turns times into cycle counts with it
  localparam int unsigned SSH_CLK_MHZ = 200;
  // host timeout length in clocks; short accesses must finish below it
  localparam int unsigned SSH_ACCESS_LIMIT = 16;
  // last busy count of a short access; completion stays high at least one cycle longer, well under the limit
  localparam logic [3:0] SSH_SHORT_BUSY = 4'h4;
  localparam logic [3:0] SSH_CNT_ZERO = 4'h0;
  localparam logic [3:0] SSH_CNT_ONE = 4'h1;
  // command codes, values arbitrary
  localparam logic [7:0] SSH_RESET_CMD = 8'h01;
  localparam logic [7:0] SSH_FIND_CMD = 8'h20;
  localparam logic [7:0] SSH_SET_LAST_POINTER_CMD = 8'h21;
  localparam logic [7:0] SSH_ONLINE_SORT_CMD = 8'h22;
  localparam logic [7:0] SSH_OFFLINE_SORT_CMD = 8'h23;
  localparam logic [7:0] SSH_BYTE_ZERO = 8'h00;
  // buffer depth
  localparam int unsigned SSH_BUF_DEPTH = 2;

  // one received byte with its command/data tag
  typedef struct packed {
    logic is_cmd;
    logic [7:0] value;
  } ssh_byte_type;

  localparam ssh_byte_type SSH_BYTE_RESET = '{is_cmd: 1'b0, value: 8'h00};

  // completion line phases
  typedef enum logic [1:0] {
    SSH_DONE_IDLE,
    SSH_DONE_RELEASE,
    SSH_DONE_BUSY,
    SSH_DONE_LONG
  } ssh_done_state_type;
endpackage
`default_nettype wire

// ===== hdl/ssh_byte_buffer.sv
// two-entry buffer for received bytes, valid/ready on both sides
// assumes both sides run on mclk_in; full stalls the writer
`default_nettype none
module ssh_byte_buffer
  import ssh_pkg::*;
(
  // clock and reset
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic clear_in,
  // filling side
  input wire logic in_valid_in,
  input wire ssh_byte_type in_data_in,
  output logic in_ready_out,
  // draining side
  output logic out_valid_out,
  output ssh_byte_type out_data_out,
  input wire logic out_ready_in
);
  ssh_byte_type store_r [SSH_BUF_DEPTH];
  logic wr_ptr_r;
  logic rd_ptr_r;
  logic [1:0] count_r;
  logic push;
  logic pop;

  // honest full and empty from the count
  assign in_ready_out = (count_r != 2'h2);
  assign out_valid_out = (count_r != 2'h0);
  assign out_data_out = store_r[rd_ptr_r];
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;

  // storage write, no reset needed on data
  always_ff @(posedge mclk_in) begin
    if (push) begin
      store_r[wr_ptr_r] <= in_data_in;
    end
  end

  // pointers and occupancy
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      count_r <= 2'h0;
    end else if (clear_in) begin
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      count_r <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr_r <= ~wr_ptr_r;
      end
      if (pop) begin
        rd_ptr_r <= ~rd_ptr_r;
      end
      count_r <= count_r + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule
`default_nettype wire

// ===== hdl/ssh_device.sv
// search sorter device: host-facing pin logic of one device in a bank
// assumes all pins are asynchronous to mclk_in and are synchronised here
`default_nettype none
//
// Contract
// - sample bus while writing, keep last
// - transfer direction low while reading
// - transmitting device drives own direction low
// - exception output low on fault; lowered only outside SSH_DONE_IDLE or with rx_valid_out high
// - separate completion and global buffer directions
// - chain end inputs pulled high for enumeration
// - reset on power-up, command or pin
// - short accesses finish under sixteen clocks
// - completion tristated, then driven high busy
module ssh_device
  import ssh_pkg::*;
(
  // clock and power-up reset
  input wire logic mclk_in,
  input wire logic resetn_in,
  // host strobes and selects (pins)
  input wire logic chip_select_n_in,
  input wire logic write_strobe_n_in,
  input wire logic read_strobe_n_in,
  input wire logic cmd_data_sel_in,
  input wire logic reset_pin_n_in,
  // shared data bus (pins)
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe_out,
  // completion line, driven high or low, released to a pull-up (pins)
  input wire logic completion_in,
  output logic completion_out,
  output logic completion_oe_out,
  // global inter-chip line (pins)
  input wire logic global_in,
  output logic global_out,
  output logic global_oe_out,
  // bank buffer control (pins)
  output logic transfer_dir_out,
  output logic completion_buffer_dir_out,
  output logic global_buffer_dir_out,
  output logic exception_n_out,
  // daisy chain (pins)
  input wire logic chain_in_upward,
  input wire logic chain_in_downward,
  output logic chain_out_upward,
  output logic chain_out_downward,
  // user side: received bytes
  output logic rx_valid_out,
  output ssh_byte_type rx_data_out,
  input wire logic rx_ready_in,
  // user side: read data and core events
  input wire logic [7:0] read_data_in,
  input wire logic long_done_in,
  input wire logic exception_in,
  input wire logic exception_clear_in,
  input wire logic offline_tx_in,
  input wire logic global_drive_in,
  // user side: status
  output logic first_device_out,
  output logic last_device_out,
  output logic global_level_out,
  output logic completion_level_out
);
  // two-flop synchronisers for every pin input
  logic [14:0] sync1_r;
  logic [14:0] sync2_r;
  logic cs_n_s;
  logic wr_n_s;
  logic rd_n_s;
  logic cd_s;
  logic rst_pin_n_s;
  logic up_s;
  logic down_s;
  logic glob_s;
  logic comp_s;
  logic [7:0] data_s;
  logic [14:0] pins;

  assign pins = {data_in, completion_in, global_in, chain_in_downward, chain_in_upward,
                 reset_pin_n_in, cmd_data_sel_in, read_strobe_n_in & write_strobe_n_in};
  // first stage read only by second stage
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sync1_r <= 15'h7fff;
      sync2_r <= 15'h7fff;
    end else begin
      sync1_r <= pins;
      sync2_r <= sync1_r;
    end
  end

  // strobe pins synchronised separately so they stay distinct
  logic [2:0] strb1_r;
  logic [2:0] strb2_r;
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      strb1_r <= 3'h7;
      strb2_r <= 3'h7;
    end else begin
      strb1_r <= {chip_select_n_in, write_strobe_n_in, read_strobe_n_in};
      strb2_r <= strb1_r;
    end
  end

  assign cs_n_s = strb2_r[2];
  assign wr_n_s = strb2_r[1];
  assign rd_n_s = strb2_r[0];
  assign cd_s = sync2_r[1];
  assign rst_pin_n_s = sync2_r[2];
  assign up_s = sync2_r[3];
  assign down_s = sync2_r[4];
  assign glob_s = sync2_r[5];
  assign comp_s = sync2_r[6];
  assign data_s = sync2_r[14:7];

  // qualified accesses
  logic wr_act;
  logic rd_act;
  logic acc_act_d_r;
  logic wr_act_d_r;
  logic soft_rst_r;
  logic int_rst;

  assign wr_act = ~wr_n_s & ~cs_n_s;
  assign rd_act = ~rd_n_s & ~cs_n_s;
  // internal reset
  // pin or reset command clears pending, buffer, completion and exception state and reloads the chain ends
  assign int_rst = soft_rst_r | ~rst_pin_n_s;

  // access edge history
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      acc_act_d_r <= 1'b0;
      wr_act_d_r <= 1'b0;
    end else begin
      acc_act_d_r <= wr_act | rd_act;
      wr_act_d_r <= wr_act;
    end
  end

  // write sampling
  ssh_byte_type sample_r;
  ssh_byte_type pend_r;
  logic pend_valid_r;
  logic buf_in_ready;
  logic wr_end;
  logic is_reset_cmd;
  logic is_long_cmd;

  assign wr_end = wr_act_d_r & ~wr_act;
  assign is_reset_cmd = sample_r.is_cmd & (sample_r.value == SSH_RESET_CMD);
  assign is_long_cmd = pend_r.is_cmd & ((pend_r.value == SSH_FIND_CMD) |
                       (pend_r.value == SSH_SET_LAST_POINTER_CMD) |
                       (pend_r.value == SSH_ONLINE_SORT_CMD) |
                       (pend_r.value == SSH_OFFLINE_SORT_CMD));

  // last sample kept
  // every active cycle overwrites, so the value before release wins
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sample_r <= SSH_BYTE_RESET;
    end else if (wr_act) begin
      sample_r <= '{is_cmd: cd_s, value: data_s};
    end
  end

  // completed write waits here until the buffer takes it
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pend_r <= SSH_BYTE_RESET;
      pend_valid_r <= 1'b0;
      soft_rst_r <= 1'b0;
    end else if (int_rst) begin
      pend_valid_r <= 1'b0;
      soft_rst_r <= 1'b0;
    end else begin
      soft_rst_r <= wr_end & is_reset_cmd;
      if (wr_end & ~is_reset_cmd) begin
        pend_r <= sample_r;
        pend_valid_r <= 1'b1;
      end else if (buf_in_ready) begin
        pend_valid_r <= 1'b0;
      end
    end
  end

  // received bytes toward the core; a stall holds completion busy
  ssh_byte_buffer u_rx_buf (
    .mclk_in(mclk_in),
    .resetn_in(resetn_in),
    .clear_in(int_rst),
    .in_valid_in(pend_valid_r),
    .in_data_in(pend_r),
    .in_ready_out(buf_in_ready),
    .out_valid_out(rx_valid_out),
    .out_data_out(rx_data_out),
    .out_ready_in(rx_ready_in)
  );

  // completion line sequencing
  ssh_done_state_type done_state_r;
  logic [3:0] busy_cnt_r;
  logic long_r;
  logic acc_start;

  assign acc_start = (wr_act | rd_act) & ~acc_act_d_r;

  // release then busy
  // one cycle tristated, then driven high while the access runs
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      done_state_r <= SSH_DONE_IDLE;
      busy_cnt_r <= SSH_CNT_ZERO;
      long_r <= 1'b0;
    end else if (int_rst) begin
      done_state_r <= SSH_DONE_IDLE;
      busy_cnt_r <= SSH_CNT_ZERO;
      long_r <= 1'b0;
    end else begin
      if (pend_valid_r & buf_in_ready & is_long_cmd) begin
        long_r <= 1'b1;
      end
      case (done_state_r)
        SSH_DONE_IDLE: begin
          if (acc_start) begin
            done_state_r <= SSH_DONE_RELEASE;
          end
        end
        SSH_DONE_RELEASE: begin
          done_state_r <= SSH_DONE_BUSY;
          busy_cnt_r <= SSH_CNT_ZERO;
        end
        // short access bound
        // fixed short count, kept well under the host limit
        SSH_DONE_BUSY: begin
          if (busy_cnt_r != SSH_SHORT_BUSY) begin
            busy_cnt_r <= busy_cnt_r + SSH_CNT_ONE;
          end else if (~wr_act & ~rd_act & ~pend_valid_r & ~wr_end) begin
            done_state_r <= long_r ? SSH_DONE_LONG : SSH_DONE_IDLE;
          end
        end
        SSH_DONE_LONG: begin
          if (long_done_in) begin
            done_state_r <= SSH_DONE_IDLE;
            long_r <= 1'b0;
          end
        end
        default: done_state_r <= SSH_DONE_IDLE;
      endcase
    end
  end

  // pin drivers, all from flops
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      completion_out <= 1'b0;
      completion_oe_out <= 1'b1;
      completion_buffer_dir_out <= 1'b1;
    end else begin
      completion_out <= (done_state_r == SSH_DONE_BUSY) | (done_state_r == SSH_DONE_LONG);
      completion_oe_out <= (done_state_r != SSH_DONE_RELEASE);
      completion_buffer_dir_out <= (done_state_r != SSH_DONE_RELEASE);
    end
  end

  // read data driven while the read is qualified
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      data_out <= SSH_BYTE_ZERO;
      data_oe_out <= 1'b0;
      transfer_dir_out <= 1'b1;
    end else begin
      if (rd_act & ~acc_act_d_r) begin
        data_out <= read_data_in;
      end
      data_oe_out <= rd_act;
      transfer_dir_out <= ~(rd_act | offline_tx_in);
    end
  end

  // global line and its buffer direction
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      global_out <= 1'b0;
      global_oe_out <= 1'b0;
      global_buffer_dir_out <= 1'b0;
      global_level_out <= 1'b1;
      completion_level_out <= 1'b1;
    end else begin
      global_out <= 1'b0;
      global_oe_out <= global_drive_in;
      global_buffer_dir_out <= global_drive_in;
      global_level_out <= glob_s;
      completion_level_out <= comp_s;
    end
  end

  // exception flag
  // a raise, taken only outside SSH_DONE_IDLE or with rx_valid_out high, wins over a clear in the same cycle
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      exception_n_out <= 1'b1;
    end else if (exception_in & (done_state_r != SSH_DONE_IDLE | rx_valid_out)) begin
      exception_n_out <= 1'b0;
    end else if (exception_clear_in | int_rst) begin
      exception_n_out <= 1'b1;
    end
  end

  // chain enumeration
  // ends are found from the pulled-high inputs, token passed along
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      chain_out_upward <= 1'b0;
      chain_out_downward <= 1'b0;
      first_device_out <= 1'b0;
      last_device_out <= 1'b0;
    end else begin
      chain_out_downward <= up_s;
      chain_out_upward <= down_s;
      if (int_rst | ~first_device_out) begin
        first_device_out <= up_s;
      end
      if (int_rst | ~last_device_out) begin
        last_device_out <= down_s;
      end
    end
  end
endmodule
`default_nettype wire

// ===== verification/ssh_device_sva.sv
// checker: pin timing relations of one device
// assumes bind onto ssh_device, one clock domain
`default_nettype none
module ssh_device_sva (
  // clock and reset
  input wire logic mclk_in,
  input wire logic resetn_in,
  // inputs watched
  input wire logic read_strobe_n_in,
  input wire logic reset_pin_n_in,
  input wire logic chain_in_upward,
  input wire logic chain_in_downward,
  input wire logic exception_in,
  input wire logic exception_clear_in,
  input wire logic offline_tx_in,
  input wire logic global_drive_in,
  // outputs watched
  input wire logic completion_out,
  input wire logic completion_oe_out,
  input wire logic completion_buffer_dir_out,
  input wire logic global_out,
  input wire logic global_oe_out,
  input wire logic transfer_dir_out,
  input wire logic exception_n_out,
  input wire logic chain_out_upward,
  input wire logic chain_out_downward
);
  timeunit 1ns;
  timeprecision 1ps;
  // one domain, so clock and reset are given once
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!resetn_in);
  // repeat counts cover synchroniser and output flops, plus a spare cycle except in a_dir_idle
  a_chain_down: assert property (chain_in_upward [*5] |-> chain_out_downward)
    else $error("chain_out_downward lost chain_in_upward");
  a_chain_up: assert property ((!chain_in_downward) [*5] |-> !chain_out_upward)
    else $error("chain_out_upward lost chain_in_downward");
  a_dir_offline: assert property (offline_tx_in |=> !transfer_dir_out)
    else $error("transfer_dir_out high while transmitting");
  a_dir_idle: assert property ((read_strobe_n_in && !offline_tx_in) [*4] |-> transfer_dir_out)
    else $error("transfer_dir_out low while idle");
  a_exc_set: assert property ($fell(exception_n_out) |-> $past(exception_in))
    else $error("exception_n_out fell without a fault");
  a_exc_clear: assert property (exception_clear_in && !exception_in |=> exception_n_out)
    else $error("exception_n_out not cleared");
  a_done_release: assert property ($fell(completion_oe_out) |=> completion_oe_out && completion_out)
    else $error("completion not driven high after release");
  a_done_bufdir: assert property (completion_buffer_dir_out == completion_oe_out)
    else $error("completion buffer direction off");
  a_global_drive: assert property (global_drive_in |=> global_oe_out && !global_out)
    else $error("global line not driven");
  a_pin_reset: assert property ((!reset_pin_n_in) [*6] |-> completion_oe_out && !completion_out)
    else $error("reset pin did not idle completion");
endmodule
`default_nettype wire

// ===== verification/ssh_host_model.sv
// host model: select, strobes and data bus toward one device
// assumes the bench calls access(); completion has a pull-up
`default_nettype none
module ssh_host_model (
  // clock and device outputs
  input wire logic mclk_in,
  input wire logic [7:0] data_in,
  input wire logic data_oe_in,
  input wire logic completion_in,
  input wire logic completion_oe_in,
  // pins toward the device
  output logic chip_select_n_out = 1'b1,
  output logic write_strobe_n_out = 1'b1,
  output logic read_strobe_n_out = 1'b1,
  output logic cmd_data_sel_out = 1'b0,
  output logic [7:0] bus_out,
  output logic done_out,
  output logic timeout_irq_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] byte_q = 8'h00;
  logic drive_q = 1'b0;
  logic [4:0] cnt_r = 5'h00;
  assign done_out = completion_oe_in ? completion_in : 1'b1;
  // released bus shows the inverse, so a stale byte never passes
  assign bus_out = data_oe_in ? data_in : (drive_q ? byte_q : ~byte_q);
  always_ff @(posedge mclk_in) begin
    if (chip_select_n_out) begin
      cnt_r <= 5'h00;
    end else if (cnt_r != 5'h10) begin
      cnt_r <= cnt_r + 5'h01;
    end
  end
  assign timeout_irq_out = (cnt_r == 5'h10);
  task automatic access(input logic wr, input logic cd, input logic [7:0] b0,
      input logic [7:0] b1, output logic [7:0] rd, output logic tmo);
    @(negedge mclk_in);
    chip_select_n_out = 1'b0;
    cmd_data_sel_out = cd;
    rd = 8'h00;
    while (done_out !== 1'b0 && timeout_irq_out !== 1'b1) begin
      @(negedge mclk_in);
    end
    tmo = timeout_irq_out;
    if (!tmo) begin
      byte_q = b0;
      // bus driven from the strobe until chip select rises
      drive_q = wr;
      write_strobe_n_out = !wr;
      read_strobe_n_out = wr;
      // final byte held, falling edge read
      for (int i = 0; i < 11; i++) begin
        @(negedge mclk_in);
        if (i == 4) byte_q = b1;
        if (!wr && i < 8) rd = bus_out;
        if (i == 7) write_strobe_n_out = 1'b1;
        if (i == 7) read_strobe_n_out = 1'b1;
      end
    end
    drive_q = 1'b0;
    chip_select_n_out = 1'b1;
  endtask
endmodule
`default_nettype wire

// ===== verification/search_sorter_host_interface_bench.sv
// bench for ssh_device: host model on the pins, bench on the user side
// assumes ssh_pkg, the checker and ssh_host_model compile first
`default_nettype none
module search_sorter_host_interface_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import ssh_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, rpn = 1'b1, up = 1'b1, dn = 1'b1, rxr = 1'b0;
  logic ld = 1'b0, exi = 1'b0, exc = 1'b0, otx = 1'b0, gdr = 1'b0, tmo;
  logic [7:0] rdd = 8'h00, dout, bus, rd;
  logic cs_n, we_n, re_n, cd, doe, done, co, coe, gout, goe, gin, tdir, exn, ocu, rxv;
  ssh_byte_type rxd;
  int fails = 0, total_checks = 0, cyc = 0;
  // global line has no keeper: released shows the inverse
  assign gin = goe ? gout : ~gout;
  // 200 MHz clock
  initial forever #2.5 clk = ~clk;
  ssh_device u_dut (
    .mclk_in(clk), .resetn_in(rst_n), .chip_select_n_in(cs_n), .write_strobe_n_in(we_n),
    .read_strobe_n_in(re_n), .cmd_data_sel_in(cd), .reset_pin_n_in(rpn), .data_in(bus),
    .data_out(dout), .data_oe_out(doe), .completion_in(done), .completion_out(co),
    .completion_oe_out(coe), .global_in(gin), .global_out(gout), .global_oe_out(goe),
    .transfer_dir_out(tdir), .completion_buffer_dir_out(), .global_buffer_dir_out(),
    .exception_n_out(exn), .chain_in_upward(up), .chain_in_downward(dn),
    .chain_out_upward(ocu), .chain_out_downward(), .rx_valid_out(rxv), .rx_data_out(rxd),
    .rx_ready_in(rxr), .read_data_in(rdd), .long_done_in(ld), .exception_in(exi),
    .exception_clear_in(exc), .offline_tx_in(otx), .global_drive_in(gdr),
    .first_device_out(), .last_device_out(), .global_level_out(), .completion_level_out()
  );
  ssh_host_model u_host (
    .mclk_in(clk), .data_in(dout), .data_oe_in(doe), .completion_in(co),
    .completion_oe_in(coe), .chip_select_n_out(cs_n), .write_strobe_n_out(we_n),
    .read_strobe_n_out(re_n), .cmd_data_sel_out(cd), .bus_out(bus), .done_out(done),
    .timeout_irq_out()
  );
  task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test();
    if (fails == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // bounded wait for a received byte, then one handshake
  task automatic pop(input logic [8:0] exp);
    for (int n = 0; n < 200 && rxv !== 1'b1; n++) @(negedge clk);
    check("rx_data", rxd, exp);
    rxr = 1'b1;
    @(negedge clk);
    rxr = 1'b0;
  endtask
  task automatic idle();
    for (int n = 0; n < 400 && done !== 1'b0; n++) @(negedge clk);
  endtask
  task automatic t_reset();
    check("transfer_dir", {8'h00, tdir}, 9'h001);
    check("exception_n", {8'h00, exn}, 9'h001);
    check("completion", {6'h00, doe, coe, co}, 9'h002);
  endtask
  // data changed mid-strobe: the last byte must win
  task automatic t_write();
    u_host.access(1'b1, 1'b0, 8'h5a, 8'ha5, rd, tmo);
    check("timeout", {8'h00, tmo}, 9'h000);
    pop(9'h0a5);
  endtask
  // receiver stalls: two bytes buffered, the third holds busy
  task automatic t_fill();
    u_host.access(1'b1, 1'b1, 8'h30, 8'h30, rd, tmo);
    u_host.access(1'b1, 1'b0, 8'h11, 8'h11, rd, tmo);
    u_host.access(1'b1, 1'b0, 8'h12, 8'h12, rd, tmo);
    repeat (20) @(negedge clk);
    check("busy held", {8'h00, done}, 9'h001);
    pop(9'h130);
    pop(9'h011);
    pop(9'h012);
    idle();
  endtask
  task automatic t_read();
    rdd = 8'hc3;
    fork
      u_host.access(1'b0, 1'b0, 8'h00, 8'h00, rd, tmo);
      begin
        repeat (6) @(negedge clk);
        check("transfer_dir", {8'h00, tdir}, 9'h000);
      end
    join
    check("read byte", {1'b0, rd}, 9'h0c3);
    idle();
  endtask
  // every long command outlasts the host timeout
  task automatic t_long();
    logic [7:0] codes [4];
    codes = '{SSH_FIND_CMD, SSH_SET_LAST_POINTER_CMD, SSH_ONLINE_SORT_CMD, SSH_OFFLINE_SORT_CMD};
    foreach (codes[i]) begin
      u_host.access(1'b1, 1'b1, codes[i], codes[i], rd, tmo);
      exi = (i == 0);
      @(negedge clk);
      exi = 1'b0;
      @(negedge clk);
      // single bank line read after the access
      check("exception_n", {8'h00, exn}, {8'h00, i != 0});
      exc = 1'b1;
      @(negedge clk);
      exc = 1'b0;
      u_host.access(1'b1, 1'b0, 8'h44, 8'h44, rd, tmo);
      check("timeout", {8'h00, tmo}, 9'h001);
      check("exception_n", {8'h00, exn}, 9'h001);
      ld = 1'b1;
      @(negedge clk);
      ld = 1'b0;
      idle();
      check("busy", {8'h00, done}, 9'h000);
      pop({1'b1, codes[i]});
    end
  endtask
  task automatic t_misc();
    u_host.access(1'b1, 1'b1, SSH_RESET_CMD, SSH_RESET_CMD, rd, tmo);
    idle();
    repeat (4) @(negedge clk);
    check("rx_valid", {8'h00, rxv}, 9'h000);
    // host resets the devices by pin
    rpn = 1'b0;
    repeat (8) @(negedge clk);
    rpn = 1'b1;
    otx = 1'b1;
    dn = 1'b0;
    gdr = 1'b1;
    repeat (6) @(negedge clk);
    check("transfer_dir", {8'h00, tdir}, 9'h000);
    check("chain_out_upward", {8'h00, ocu}, 9'h000);
    otx = 1'b0;
    dn = 1'b1;
    gdr = 1'b0;
    repeat (10) @(negedge clk);
  endtask
  // main sequence
  initial begin
    repeat (12) @(negedge clk);
    t_reset();
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    t_write();
    t_fill();
    t_read();
    t_long();
    t_misc();
    end_of_test();
  end
  // ceiling far above the few hundred cycles the scenarios need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      end_of_test();
    end
  end
endmodule
bind ssh_device ssh_device_sva u_sva (
  .mclk_in(mclk_in), .resetn_in(resetn_in), .read_strobe_n_in(read_strobe_n_in),
  .reset_pin_n_in(reset_pin_n_in), .chain_in_upward(chain_in_upward),
  .chain_in_downward(chain_in_downward), .exception_in(exception_in),
  .exception_clear_in(exception_clear_in), .offline_tx_in(offline_tx_in),
  .global_drive_in(global_drive_in), .completion_out(completion_out),
  .completion_oe_out(completion_oe_out), .completion_buffer_dir_out(completion_buffer_dir_out),
  .global_out(global_out), .global_oe_out(global_oe_out), .transfer_dir_out(transfer_dir_out),
  .exception_n_out(exception_n_out), .chain_out_upward(chain_out_upward),
  .chain_out_downward(chain_out_downward)
);
`default_nettype wire
